// *** logic/hpm_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Pads high impedance in reset; data-3 pulled up
// - UART host uses serial in/out pads
// - Serial out driven only in UART host mode
// - UART host only in embedded firmware mode
// - Flow control uses clear/request-to-send pads
// - Clock pad carries SDIO or SPI clock
// - Command pad: SDIO command or SPI select
// - Data-0/1 carry SDIO bits or MOSI/MISO
// - Data-2: SDIO bit or SPI interrupt out
// - Data-3: SDIO bit or SPI fault interrupt
// - USB mode: data-3 is CDC disable input
// - Audio pads take I2S or PCM role
// - Audio input pad sampled when configured
// - Own transmit busy pad driven when coexistence enabled
// - UART host: pending packet held until host ready
// - Wake-host pad driven when configured
// - Debug serial out after firmware load
// - Default after boot; sleep lowers indicator
//////////////////////////////////////////////////////////////////////////////
package hpm_pkg;

  // Pad indices
  localparam int NPAD = 19;
  localparam int PAD_SER_IN = 0;
  localparam int PAD_SER_OUT = 1;
  localparam int PAD_AUD_DOUT = 2;
  localparam int PAD_AUD_CLK = 3;
  localparam int PAD_AUD_DIN = 4;
  localparam int PAD_AUD_WS = 5;
  localparam int PAD_RTS = 6;
  localparam int PAD_CTS = 7;
  localparam int PAD_CARD_CLK = 8;
  localparam int PAD_CARD_CMD = 9;
  localparam int PAD_CARD_D0 = 10;
  localparam int PAD_CARD_D1 = 11;
  localparam int PAD_CARD_D2 = 12;
  localparam int PAD_CARD_D3 = 13;
  localparam int PAD_OWN_BUSY = 14;
  localparam int PAD_PEER_BUSY = 15;
  localparam int PAD_WAKE_IN = 16;
  localparam int PAD_WAKE_OUT = 17;
  localparam int PAD_DEBUG_TX = 18;

  // Host interface codes
  localparam logic [2:0] HOST_NONE = 3'h0;
  localparam logic [2:0] HOST_SDIO = 3'h1;
  localparam logic [2:0] HOST_SPI = 3'h2;
  localparam logic [2:0] HOST_USB = 3'h3;
  localparam logic [2:0] HOST_UART = 3'h4;

  // Audio pad roles
  localparam logic [1:0] AUD_OFF = 2'h0;
  localparam logic [1:0] AUD_I2S = 2'h1;
  localparam logic [1:0] AUD_PCM = 2'h2;

  // Wake-in pad roles
  localparam logic [1:0] WIN_OFF = 2'h0;
  localparam logic [1:0] WIN_REQUEST = 2'h1;
  localparam logic [1:0] WIN_READY = 2'h2;

  // Wake-out pad roles
  localparam logic [1:0] WOUT_OFF = 2'h0;
  localparam logic [1:0] WOUT_WAKE = 2'h1;
  localparam logic [1:0] WOUT_URGENT = 2'h2;

  // Reset values and asleep indicator level
  localparam logic PULLUP_RST = 1'h1;
  localparam logic SLEEP_IND_RST = 1'h1;
  localparam logic SLEEP_IND_ASLEEP = 1'h0;

  typedef enum logic [3:0] {
    PH_RESET = 4'h1,
    PH_BOOT = 4'h2,
    PH_ACTIVE = 4'h4,
    PH_SLEEP = 4'h8
  } hpm_phase_t;

  typedef struct packed {
    logic o;
    logic oe_n;
  } hpm_pad_out_t;

  localparam hpm_pad_out_t PAD_HIZ = '{o: 1'h0, oe_n: 1'h1};

  typedef struct packed {
    logic flow_ctrl_en;
    logic coex_en;
    logic [1:0] wake_in_role;
    logic [1:0] wake_out_role;
    logic debug_tx_disable;
    logic [3:0][1:0] audio_role;
  } hpm_cfg_t;

  typedef struct packed {
    logic host_serial_out;
    logic host_request_to_send;
    logic card_cmd_o;
    logic card_cmd_oe;
    logic [3:0] card_bus_o;
    logic [3:0] card_bus_oe;
    logic master_in_slave_out;
    logic host_irq_out;
    logic bus_fault_irq_out;
    logic own_tx_busy;
    logic wake_host;
    logic debug_serial_out;
  } hpm_core_out_t;

  typedef struct packed {
    logic host_serial_in;
    logic host_clear_to_send;
    logic card_clk;
    logic card_cmd_i;
    logic [3:0] card_bus_i;
    logic spi_clk;
    logic slave_select_n;
    logic master_out_slave_in;
    logic cdc_function_disable;
    logic peer_tx_busy;
    logic peer_tx_urgent;
    logic host_wake_request;
    logic host_ready;
  } hpm_core_in_t;

  localparam hpm_core_in_t CORE_IN_IDLE = '{slave_select_n: 1'h1,
                                            default: '0};

  typedef struct packed {
    logic i2s_clk;
    logic i2s_dout;
    logic audio_word_select;
    logic pcm_clk;
    logic pcm_dout;
    logic voice_frame_sync;
  } hpm_aud_src_t;

  typedef struct packed {
    logic i2s_din;
    logic pcm_din;
  } hpm_aud_sink_t;

  function automatic hpm_pad_out_t drive(input logic val, input logic en);
    hpm_pad_out_t p;
    p.o = val & en;
    p.oe_n = ~en;
    return p;
  endfunction

  // Picks the I2S or PCM signal for a pad, off when unassigned
  function automatic hpm_pad_out_t aud_pick(input logic [1:0] role,
                                            input logic i2s_v,
                                            input logic pcm_v);
    hpm_pad_out_t p;
    p = PAD_HIZ;
    if (role == AUD_I2S)
      p = drive(i2s_v, 1'b1);
    else if (role == AUD_PCM)
      p = drive(pcm_v, 1'b1);
    return p;
  endfunction

endpackage

// *** logic/hpm_host_sel.sv ***
`timescale 1ns/1ps
module hpm_host_sel
  import hpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] host_strap,
  input wire logic fw_embedded,
  input wire logic boot_done,
  input wire logic sleep_req,
  output hpm_phase_t phase,
  output logic [2:0] host
);

  hpm_phase_t phase_q, phase_d;
  logic [2:0] strap_q, strap_d;
  logic emb_q, emb_d;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    phase_d = phase_q;
    strap_d = strap_q;
    emb_d = emb_q;
    case (phase_q)
      PH_RESET:
      begin
        // Caught once after release, held to next reset
        strap_d = host_strap;
        emb_d = fw_embedded;
        phase_d = PH_BOOT;
      end
      PH_BOOT:
        if (boot_done)
          phase_d = PH_ACTIVE;
      PH_ACTIVE:
        if (sleep_req)
          phase_d = PH_SLEEP;
      PH_SLEEP:
        if (!sleep_req)
          phase_d = PH_ACTIVE;
      default:
        phase_d = PH_RESET;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase_q <= PH_RESET;
      strap_q <= HOST_NONE;
      emb_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      strap_q <= strap_d;
      emb_q <= emb_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // UART and SPI exist only in embedded firmware
  always_comb
  begin
    case (strap_q)
      HOST_SDIO: host = HOST_SDIO;
      HOST_USB: host = HOST_USB;
      HOST_SPI: host = emb_q ? HOST_SPI : HOST_NONE;
      HOST_UART: host = emb_q ? HOST_UART : HOST_NONE;
      default: host = HOST_NONE;
    endcase
  end

  assign phase = phase_q;

endmodule // hpm_host_sel

// *** logic/hpm_audio_mux.sv ***
`timescale 1ns/1ps
module hpm_audio_mux
  import hpm_pkg::*;
(
  input wire logic active,
  input wire logic [3:0][1:0] role,
  input wire hpm_aud_src_t src,
  input wire logic din_pad,
  output hpm_pad_out_t clk_pad,
  output hpm_pad_out_t dout_pad,
  output hpm_pad_out_t ws_pad,
  output hpm_aud_sink_t sink
);

  // Role slots: 0 clock, 1 output data, 2 input data, 3 word select
  logic [1:0] r_clk, r_dout, r_din, r_ws;

  always_comb
  begin
    r_clk = active ? role[0] : AUD_OFF;
    r_dout = active ? role[1] : AUD_OFF;
    r_din = active ? role[2] : AUD_OFF;
    r_ws = active ? role[3] : AUD_OFF;
    clk_pad = aud_pick(r_clk, src.i2s_clk, src.pcm_clk);
    dout_pad = aud_pick(r_dout, src.i2s_dout, src.pcm_dout);
    ws_pad = aud_pick(r_ws, src.audio_word_select, src.voice_frame_sync);
    sink.i2s_din = (r_din == AUD_I2S) & din_pad;
    sink.pcm_din = (r_din == AUD_PCM) & din_pad;
  end

endmodule // hpm_audio_mux

// *** logic/hpm_pin_mux.sv ***
`timescale 1ns/1ps
module hpm_pin_mux
  import hpm_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [2:0] HOST_STRAP,
  input wire logic FW_EMBEDDED,
  input wire logic BOOT_DONE,
  input wire logic SLEEP_REQ,
  input wire hpm_cfg_t CFG,
  input wire logic [NPAD-1:0] PAD_IN,
  output hpm_pad_out_t [NPAD-1:0] PAD_OUT,
  output logic D3_PULLUP_EN,
  output logic SLEEP_INDICATOR,
  output logic [2:0] HOST_MODE,
  input wire hpm_core_out_t CORE_OUT,
  output hpm_core_in_t CORE_IN,
  input wire hpm_aud_src_t AUD_SRC,
  output hpm_aud_sink_t AUD_SINK,
  input wire logic PKT_PENDING,
  output logic PKT_RELEASE
);

  hpm_phase_t phase;
  logic [2:0] host;
  logic active;
  hpm_pad_out_t aud_clk, aud_dout, aud_ws;
  hpm_aud_sink_t aud_sink;

  hpm_pad_out_t [NPAD-1:0] pad_q, pad_d;
  hpm_core_in_t cin_q, cin_d;
  hpm_aud_sink_t sink_q, sink_d;
  logic pullup_q, pullup_d;
  logic sleep_q, sleep_d;
  logic rel_q, rel_d;
  logic [2:0] mode_q, mode_d;

  //////////////////////////////////////////////////////////////////////////////
  hpm_host_sel u_host_sel (
    .clk(CLK),
    .rst(RST),
    .host_strap(HOST_STRAP),
    .fw_embedded(FW_EMBEDDED),
    .boot_done(BOOT_DONE),
    .sleep_req(SLEEP_REQ),
    .phase(phase),
    .host(host)
  );

  // Pads keep defaults until boot and firmware loading finish
  assign active = (phase == PH_ACTIVE);

  hpm_audio_mux u_audio_mux (
    .active(active),
    .role(CFG.audio_role),
    .src(AUD_SRC),
    .din_pad(PAD_IN[PAD_AUD_DIN]),
    .clk_pad(aud_clk),
    .dout_pad(aud_dout),
    .ws_pad(aud_ws),
    .sink(aud_sink)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Host interface pads
  always_comb
  begin
    for (int i = 0; i < NPAD; i++)
      pad_d[i] = PAD_HIZ;
    cin_d = CORE_IN_IDLE;
    rel_d = 1'b0;
    mode_d = active ? host : HOST_NONE;
    // Pull-up only while powering up or loading, not in sleep
    pullup_d = (phase == PH_RESET) || (phase == PH_BOOT);
    sleep_d = (phase == PH_SLEEP) ? SLEEP_IND_ASLEEP
                                  : SLEEP_IND_RST;
    if (active)
    begin
      case (host)
        HOST_UART:
        begin
          cin_d.host_serial_in = PAD_IN[PAD_SER_IN];
          pad_d[PAD_SER_OUT] =
            drive(CORE_OUT.host_serial_out, 1'b1);
          if (CFG.flow_ctrl_en)
          begin
            cin_d.host_clear_to_send = PAD_IN[PAD_CTS];
            pad_d[PAD_RTS] =
              drive(CORE_OUT.host_request_to_send, 1'b1);
          end
          // Packet waits for the host to show it is ready
          rel_d = PKT_PENDING & (CFG.wake_in_role == WIN_READY) &
                  PAD_IN[PAD_WAKE_IN];
          cin_d.host_ready = (CFG.wake_in_role == WIN_READY) &
                             PAD_IN[PAD_WAKE_IN];
        end
        HOST_SDIO:
        begin
          cin_d.card_clk = PAD_IN[PAD_CARD_CLK];
          cin_d.card_cmd_i = PAD_IN[PAD_CARD_CMD];
          pad_d[PAD_CARD_CMD] =
            drive(CORE_OUT.card_cmd_o, CORE_OUT.card_cmd_oe);
          for (int b = 0; b < 4; b++)
          begin
            cin_d.card_bus_i[b] = PAD_IN[PAD_CARD_D0 + b];
            pad_d[PAD_CARD_D0 + b] =
              drive(CORE_OUT.card_bus_o[b],
                    CORE_OUT.card_bus_oe[b]);
          end
        end
        HOST_SPI:
        begin
          cin_d.spi_clk = PAD_IN[PAD_CARD_CLK];
          cin_d.slave_select_n = PAD_IN[PAD_CARD_CMD];
          cin_d.master_out_slave_in = PAD_IN[PAD_CARD_D0];
          // Drive MISO only while addressed to avoid bus contention
          pad_d[PAD_CARD_D1] =
            drive(CORE_OUT.master_in_slave_out,
                  ~PAD_IN[PAD_CARD_CMD]);
          pad_d[PAD_CARD_D2] =
            drive(CORE_OUT.host_irq_out, 1'b1);
          pad_d[PAD_CARD_D3] =
            drive(CORE_OUT.bus_fault_irq_out, 1'b1);
        end
        HOST_USB:
          cin_d.cdc_function_disable = PAD_IN[PAD_CARD_D3];
        default:
          ;
      endcase

      // Audio
      pad_d[PAD_AUD_CLK] = aud_clk;
      pad_d[PAD_AUD_DOUT] = aud_dout;
      pad_d[PAD_AUD_WS] = aud_ws;

      // Coexistence, three wires
      if (CFG.coex_en)
      begin
        pad_d[PAD_OWN_BUSY] =
          drive(CORE_OUT.own_tx_busy, 1'b1);
        cin_d.peer_tx_busy = PAD_IN[PAD_PEER_BUSY];
      end

      // Wake pads
      if (CFG.wake_in_role == WIN_REQUEST)
        cin_d.host_wake_request = PAD_IN[PAD_WAKE_IN];
      case (CFG.wake_out_role)
        WOUT_WAKE:
          pad_d[PAD_WAKE_OUT] = drive(CORE_OUT.wake_host, 1'b1);
        WOUT_URGENT:
          cin_d.peer_tx_urgent =
            CFG.coex_en & PAD_IN[PAD_WAKE_OUT];
        default:
          ;
      endcase

      // Debug serial is on by default once firmware runs
      if (!CFG.debug_tx_disable)
        pad_d[PAD_DEBUG_TX] =
          drive(CORE_OUT.debug_serial_out, 1'b1);
    end
    else if (phase == PH_SLEEP)
    begin
      // A wake request must still reach the core while asleep
      if (CFG.wake_in_role == WIN_REQUEST)
        cin_d.host_wake_request = PAD_IN[PAD_WAKE_IN];
    end
    sink_d = aud_sink;
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      for (int i = 0; i < NPAD; i++)
        pad_q[i] <= PAD_HIZ;
      cin_q <= CORE_IN_IDLE;
      sink_q <= '0;
      pullup_q <= PULLUP_RST;
      sleep_q <= SLEEP_IND_RST;
      rel_q <= 1'b0;
      mode_q <= HOST_NONE;
    end
    else
    begin
      pad_q <= pad_d;
      cin_q <= cin_d;
      sink_q <= sink_d;
      pullup_q <= pullup_d;
      sleep_q <= sleep_d;
      rel_q <= rel_d;
      mode_q <= mode_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // All pad data comes from flops; one cycle of pad latency is the cost
  assign PAD_OUT = pad_q;
  assign CORE_IN = cin_q;
  assign AUD_SINK = sink_q;
  assign D3_PULLUP_EN = pullup_q;
  assign SLEEP_INDICATOR = sleep_q;
  assign PKT_RELEASE = rel_q;
  assign HOST_MODE = mode_q;

endmodule // hpm_pin_mux

// *** tb/hpm_pin_mux_properties.sv ***
`timescale 1ns/1ps
module hpm_pin_mux_chk
  import hpm_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SLEEP_REQ,
  input wire hpm_cfg_t CFG,
  input wire logic [NPAD-1:0] PAD_IN,
  input wire hpm_pad_out_t [NPAD-1:0] PAD_OUT,
  input wire logic D3_PULLUP_EN,
  input wire logic SLEEP_INDICATOR,
  input wire logic [2:0] HOST_MODE,
  input wire hpm_core_out_t CORE_OUT,
  input wire hpm_core_in_t CORE_IN
);
  logic all_hiz;
  always_comb
  begin
    all_hiz = 1'b1;
    for (int i = 0; i < NPAD; i++)
      all_hiz = all_hiz & (PAD_OUT[i] == PAD_HIZ);
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  property p_boot_idle;
    $fell(RST) |-> D3_PULLUP_EN && SLEEP_INDICATOR && all_hiz;
  endproperty
  a_boot_idle: assert property (p_boot_idle)
    else $error("pads not idle at release");
  property p_pullup_hiz;
    D3_PULLUP_EN |-> all_hiz && HOST_MODE == HOST_NONE;
  endproperty
  a_pullup_hiz: assert property (p_pullup_hiz)
    else $error("pad driven before boot done");
  property p_ser_out;
    !PAD_OUT[PAD_SER_OUT].oe_n |-> HOST_MODE == HOST_UART &&
      PAD_OUT[PAD_SER_OUT].o == $past(CORE_OUT.host_serial_out);
  endproperty
  a_ser_out: assert property (p_ser_out)
    else $error("serial out driven wrongly");
  property p_ser_hiz;
    HOST_MODE != HOST_UART |-> PAD_OUT[PAD_SER_IN].oe_n &&
      PAD_OUT[PAD_RTS].oe_n;
  endproperty
  a_ser_hiz: assert property (p_ser_hiz)
    else $error("serial pads driven outside serial host");
  property p_spi_irq;
    HOST_MODE == HOST_SPI |-> !PAD_OUT[PAD_CARD_D2].oe_n &&
      !PAD_OUT[PAD_CARD_D3].oe_n && PAD_OUT[PAD_CARD_CMD].oe_n &&
      PAD_OUT[PAD_CARD_D2].o == $past(CORE_OUT.host_irq_out) &&
      PAD_OUT[PAD_CARD_D3].o == $past(CORE_OUT.bus_fault_irq_out);
  endproperty
  a_spi_irq: assert property (p_spi_irq)
    else $error("slave interrupt pads wrong");
  property p_miso;
    HOST_MODE == HOST_SPI |->
      PAD_OUT[PAD_CARD_D1].oe_n == $past(PAD_IN[PAD_CARD_CMD]);
  endproperty
  a_miso: assert property (p_miso)
    else $error("slave data out not gated by select");
  property p_cdc;
    HOST_MODE == HOST_USB |-> PAD_OUT[PAD_CARD_D3].oe_n &&
      CORE_IN.cdc_function_disable == $past(PAD_IN[PAD_CARD_D3]);
  endproperty
  a_cdc: assert property (p_cdc)
    else $error("cdc disable input wrong");
  property p_coex;
    !PAD_OUT[PAD_OWN_BUSY].oe_n |-> $past(CFG.coex_en) &&
      PAD_OUT[PAD_OWN_BUSY].o == $past(CORE_OUT.own_tx_busy);
  endproperty
  a_coex: assert property (p_coex)
    else $error("own busy pad wrong");
  property p_debug;
    !PAD_OUT[PAD_DEBUG_TX].oe_n |-> !$past(CFG.debug_tx_disable) &&
      PAD_OUT[PAD_DEBUG_TX].o == $past(CORE_OUT.debug_serial_out);
  endproperty
  a_debug: assert property (p_debug)
    else $error("debug serial pad wrong");
  property p_sleep;
    !D3_PULLUP_EN && $rose(SLEEP_REQ) ##1 SLEEP_REQ |=>
      !SLEEP_INDICATOR && all_hiz && HOST_MODE == HOST_NONE;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep state late or incomplete");
  property p_host_fixed;
    $past(HOST_MODE) != HOST_NONE && HOST_MODE != HOST_NONE |->
      HOST_MODE == $past(HOST_MODE);
  endproperty
  a_host_fixed: assert property (p_host_fixed)
    else $error("host selection changed");
  property p_card_in;
    HOST_MODE == HOST_SDIO |->
      CORE_IN.card_clk == $past(PAD_IN[PAD_CARD_CLK]) &&
      CORE_IN.card_cmd_i == $past(PAD_IN[PAD_CARD_CMD]) &&
      CORE_IN.slave_select_n;
  endproperty
  a_card_in: assert property (p_card_in)
    else $error("card clock or command input wrong");
  property p_spi_in;
    HOST_MODE == HOST_SPI |->
      CORE_IN.spi_clk == $past(PAD_IN[PAD_CARD_CLK]) &&
      CORE_IN.slave_select_n == $past(PAD_IN[PAD_CARD_CMD]) &&
      CORE_IN.master_out_slave_in == $past(PAD_IN[PAD_CARD_D0]);
  endproperty
  a_spi_in: assert property (p_spi_in)
    else $error("slave clock select or data input wrong");
  // Wake request must still reach the core while asleep
  property p_sleep_wake;
    !SLEEP_INDICATOR && $past(CFG.wake_in_role) == WIN_REQUEST |->
      CORE_IN.host_wake_request == $past(PAD_IN[PAD_WAKE_IN]);
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("wake request lost in sleep");
endmodule // hpm_pin_mux_chk
bind hpm_pin_mux hpm_pin_mux_chk i_chk (.CLK, .RST, .SLEEP_REQ, .CFG,
  .PAD_IN, .PAD_OUT, .D3_PULLUP_EN, .SLEEP_INDICATOR, .HOST_MODE,
  .CORE_OUT, .CORE_IN);

// *** tb/hpm_far_end.sv ***
`timescale 1ns/1ps
module hpm_far_end
  import hpm_pkg::*;
(
  input wire logic clk,
  input wire hpm_pad_out_t [NPAD-1:0] pad_out,
  input wire logic [4:0] act,
  output logic [NPAD-1:0] pad_in
);
  logic [NPAD-1:0] far_q = '0;
  logic [NPAD-1:0] far_d;
  // Released lines other than the five set from act wander each cycle, so a stale level is never trusted
  always_comb
  begin
    far_d = ~far_q;
    far_d[PAD_CARD_CMD] = ~act[0];
    far_d[PAD_PEER_BUSY] = act[1];
    far_d[PAD_WAKE_OUT] = act[2];
    far_d[PAD_WAKE_IN] = act[3];
    far_d[PAD_AUD_DIN] = act[4];
  end
  always_ff @(posedge clk)
    far_q <= far_d;
  always_comb
    for (int i = 0; i < NPAD; i++)
      pad_in[i] = pad_out[i].oe_n ? far_q[i] : pad_out[i].o;
endmodule // hpm_far_end

// *** tb/hpm_pin_mux_bench.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    comparisons++; \
    if ((gt) !== (ex)) \
    begin \
      err_total++; \
      $display("[FAIL] %s exp %h got %h", nm, ex, gt); \
    end \
  end
module hpm_pin_mux_bench
  import hpm_pkg::*;
;
  logic CLK;
  logic RST;
  logic [2:0] HOST_STRAP;
  logic FW_EMBEDDED;
  logic BOOT_DONE;
  logic SLEEP_REQ;
  hpm_cfg_t CFG;
  logic [NPAD-1:0] PAD_IN;
  hpm_pad_out_t [NPAD-1:0] PAD_OUT;
  logic D3_PULLUP_EN;
  logic SLEEP_INDICATOR;
  logic [2:0] HOST_MODE;
  hpm_core_out_t CORE_OUT;
  hpm_core_in_t CORE_IN;
  hpm_aud_src_t AUD_SRC;
  hpm_aud_sink_t AUD_SINK;
  logic PKT_PENDING;
  logic PKT_RELEASE;
  logic [4:0] act;
  logic [15:0] ex;
  logic [15:0] obs;
  logic [15:0] exp_q[$];
  int err_total = 0;
  int comparisons = 0;
  int seed;
  hpm_pin_mux i_hpm_pin_mux (.CLK, .RST, .HOST_STRAP, .FW_EMBEDDED,
    .BOOT_DONE, .SLEEP_REQ, .CFG, .PAD_IN, .PAD_OUT, .D3_PULLUP_EN,
    .SLEEP_INDICATOR, .HOST_MODE, .CORE_OUT, .CORE_IN, .AUD_SRC,
    .AUD_SINK, .PKT_PENDING, .PKT_RELEASE);
  hpm_far_end i_hpm_far_end (.clk(CLK), .pad_out(PAD_OUT), .act(act),
    .pad_in(PAD_IN));
  assign obs = {HOST_MODE, PAD_OUT[PAD_SER_OUT], PAD_OUT[PAD_CARD_D2],
    PAD_OUT[PAD_CARD_D3], PAD_OUT[PAD_OWN_BUSY], D3_PULLUP_EN,
    SLEEP_INDICATOR, PKT_RELEASE, AUD_SINK};
  ////////////////////////////////////////
  function automatic logic [15:0] idle(input logic pu);
    return {HOST_NONE, {4{PAD_HIZ}}, pu, pu, 1'b0, 2'b00};
  endfunction
  function automatic logic [15:0] e_act(input logic [2:0] h,
    input hpm_cfg_t c, input hpm_core_out_t co, input logic [4:0] a);
    hpm_pad_out_t p1;
    hpm_pad_out_t p12;
    hpm_pad_out_t p13;
    hpm_pad_out_t p14;
    hpm_aud_sink_t s;
    p1 = PAD_HIZ;
    p12 = PAD_HIZ;
    p13 = PAD_HIZ;
    p14 = PAD_HIZ;
    if (h == HOST_UART)
      p1 = '{co.host_serial_out, 1'b0};
    if (h == HOST_SDIO)
    begin
      p12 = '{co.card_bus_o[2] & co.card_bus_oe[2], ~co.card_bus_oe[2]};
      p13 = '{co.card_bus_o[3] & co.card_bus_oe[3], ~co.card_bus_oe[3]};
    end
    if (h == HOST_SPI)
    begin
      p12 = '{co.host_irq_out, 1'b0};
      p13 = '{co.bus_fault_irq_out, 1'b0};
    end
    if (c.coex_en)
      p14 = '{co.own_tx_busy, 1'b0};
    s.i2s_din = c.audio_role[2] == AUD_I2S && a[4];
    s.pcm_din = c.audio_role[2] == AUD_PCM && a[4];
    return {h, p1, p12, p13, p14, 1'b0, 1'b1,
      h == HOST_UART && c.wake_in_role == WIN_READY && a[3], s};
  endfunction
  // Pending is held high so release depends on UART host, ready wake-in role and the ready pad
  task automatic run(input int k);
    logic [2:0] h;
    logic fw;
    logic [2:0] eh;
    logic [63:0] r;
    h = 3'(k % 5);
    fw = (k >= 5);
    r = {$random(seed), $random(seed)};
    if (k >= 10)
    begin
      h = 3'({$random(seed)} % 5);
      fw = r[50];
    end
    eh = (!fw && (h == HOST_SPI || h == HOST_UART)) ? HOST_NONE : h;
    RST <= 1'b1;
    HOST_STRAP <= h;
    FW_EMBEDDED <= fw;
    BOOT_DONE <= 1'b0;
    SLEEP_REQ <= 1'b0;
    CORE_OUT <= r[17:0];
    CFG <= r[35:21];
    act <= r[40:36];
    AUD_SRC <= r[63:58];
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    exp_q.push_back(idle(1'b1));
    @(posedge CLK);
    BOOT_DONE <= 1'b1;
    exp_q.push_back(idle(1'b1));
    @(posedge CLK);
    HOST_STRAP <= 3'({$random(seed)} % 5);
    FW_EMBEDDED <= ~fw;
    repeat (2) @(posedge CLK);
    exp_q.push_back(e_act(eh, r[35:21], r[17:0], r[40:36]));
    @(posedge CLK);
    SLEEP_REQ <= 1'b1;
    repeat (2) @(posedge CLK);
    exp_q.push_back(idle(1'b0));
    @(posedge CLK);
  endtask
  always @(negedge CLK)
    if (exp_q.size() > 0)
    begin
      ex = exp_q.pop_front();
      `CHK("outputs", ex, obs)
    end
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  initial
  begin
    repeat (2000) @(posedge CLK);
    err_total++;
    end_of_test();
  end
  initial
  begin
    seed = 32'hE3508207;
    RST = 1'b1;
    HOST_STRAP = 3'h0;
    FW_EMBEDDED = 1'b0;
    BOOT_DONE = 1'b0;
    SLEEP_REQ = 1'b0;
    CFG = '0;
    CORE_OUT = '0;
    AUD_SRC = '0;
    act = 5'h00;
    PKT_PENDING = 1'b1;
    for (int k = 0; k < 24; k++)
      run(k);
    end_of_test();
  end
endmodule // hpm_pin_mux_bench
